/* hw/ttc_pkg.sv */
// Package: constants and carrier types for the thermal clock throttle block.
// Assumes a 20 MHz core clock; all counts are in cycles of that clock.
package ttc_pkg;
	localparam int CLK_HZ = 20_000_000;
	// Longest clock-off interval in automatic throttling, in nanoseconds
	localparam int OFF_MAX_NS = 3000;
	localparam int OFF_MAX_CYC = (OFF_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
	// Modulation period is split into eighths
	localparam int EIGHTH_CYC = OFF_MAX_CYC / 8;
	localparam logic [3:0] PERIOD_STEPS = 4'h8;
	// Factory clock-on eighths for automatic throttling (4/8 = 50 percent)
	localparam logic [2:0] FACTORY_ON_EIGHTHS = 3'h4;
	// Hysteresis hold after the sensor drops, in nanoseconds
	localparam int HYST_NS = 10_000;
	localparam int HYST_CYC = (HYST_NS * (CLK_HZ / 1_000_000)) / 1000;
	// Control register field layout
	localparam int CMC_WIDTH = 5;
	localparam int CMC_EN_BIT = 4;
	localparam int CMC_DUTY_LSB = 1;
	localparam int CMC_DUTY_MSB = 3;
	localparam logic [4:0] CMC_RESET = 5'h00;

	typedef struct packed {
		logic tm_enable;
		logic hot_irq_en;
		logic cool_irq_en;
	} ttc_cfg_s;

	typedef struct packed {
		logic throttle_active;
		logic core_clk_en;
		logic irq_hot;
		logic irq_cool;
	} ttc_stat_s;

	typedef enum logic [1:0] {
		TTC_IDLE,
		TTC_AUTO,
		TTC_HYST
	} ttc_state_e;
endpackage

/* hw/ttc_pin_sync.sv */
// Three-stage synchroniser for an asynchronous pin level.
// Assumes the pin is sampled on clk; output updates when stages 2 and 3 agree.
`timescale 1ns/1ns
module ttc_pin_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic pin,
	output logic level
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	wire agree = (s2_ff == s3_ff);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_ff <= RESET_VAL;
			s2_ff <= RESET_VAL;
			s3_ff <= RESET_VAL;
			level_ff <= RESET_VAL;
		end else begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (agree) begin
				level_ff <= s3_ff;
			end
		end
	end

	assign level = level_ff;
endmodule

/* hw/ttc_top.sv */
// Thermal clock throttle: auto throttling, software modulation, hot pin, trip.
// Assumes the die sensor flags are synchronous to clk and the core reads
// core_clk_en as its clock gate.
`timescale 1ns/1ns
// How it works
// [R1] Sensor at max temperature starts clock throttling
// [R2] Throttle threshold fixed, not software visible
// [R3] Snoops pass; interrupts held until clock on
// [R4] Automatic duty cycle fixed, never modifiable
// [R5] Clock-off stretch at most three microseconds
// [R6] Throttle ends after cool and hysteresis expiry
// [R7] Platform software keeps automatic throttling enabled
// [R8] Control bit 4 starts modulation immediately
// [R9] Bits 3:1 pick on-time in eighths
// [R10] Automatic duty overrides software duty when engaged
// [R11] Hot pin driven low at max temperature
// [R12] Throttle active whenever hot pin low, enabled
// [R13] Optional interrupts on hot assert, deassert
// [R14] External low on hot pin forces throttle
// [R15] Catastrophic heat: shut down, trip held low
// [R16] Trip independent of activity, no bus cycles
// [R17] Platform removes core supply on trip
// [R18] Hot pin input synchronised before use
// [R19] Hot pin is open-drain, drive low only
module ttc_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sens_max_temp,
	input wire logic sens_trip_temp,
	input wire ttc_pkg::ttc_cfg_s cfg,
	input wire logic cmc_wr,
	input wire logic [ttc_pkg::CMC_WIDTH-1:0] cmc_wdata,
	output logic [ttc_pkg::CMC_WIDTH-1:0] cmc_rdata,
	input wire logic irq_req,
	input wire logic snoop_req,
	output logic snoop_ack,
	output logic irq_service,
	input wire logic hot_indicator_n_in,
	output logic hot_indicator_n_out,
	output logic hot_indicator_n_oe,
	output logic overheat_trip_n,
	output logic core_shutdown,
	output ttc_pkg::ttc_stat_s stat
);
	import ttc_pkg::*;

	logic [CMC_WIDTH-1:0] cmc_ff;
	ttc_state_e state_ff, nxt_state;
	logic [15:0] hyst_ff;
	logic [15:0] sub_ff;
	logic [3:0] step_ff;
	logic trip_ff;
	logic irq_pend_ff;
	logic hot_prev_ff;
	logic irq_hot_ff;
	logic irq_cool_ff;
	logic clk_en_ff;
	logic ext_level;

	// Synchronised pin level; low means someone holds the wire down
	ttc_pin_sync #(.RESET_VAL(1'b1)) u_hot_sync ( // [R18]
		.clk(clk),
		.resetn(resetn),
		.pin(hot_indicator_n_in),
		.level(ext_level)
	);

	// Threshold lives in the sensor; no register exposes it
	wire own_hot = sens_max_temp; // [R2]
	wire hot_any = own_hot | ~ext_level; // [R14]
	wire auto_on = cfg.tm_enable & (state_ff != TTC_IDLE); // [R12]
	wire sw_on = cmc_ff[CMC_EN_BIT]; // [R8]
	wire [2:0] sw_duty = cmc_ff[CMC_DUTY_MSB:CMC_DUTY_LSB]; // [R9]
	// Duty 000 is reserved; treat as the finest step so clocks still run
	wire [2:0] sw_eighths = (sw_duty == 3'h0) ? 3'h1 : sw_duty;
	wire [2:0] on_eighths = auto_on ? // [R4] [R10]
		FACTORY_ON_EIGHTHS : sw_eighths;
	wire modulating = (auto_on | sw_on) & ~trip_ff;
	wire step_end = (sub_ff == 16'(EIGHTH_CYC - 1));
	wire period_end = step_end & (step_ff == PERIOD_STEPS - 4'h1);
	wire on_phase = (step_ff < {1'b0, on_eighths});
	wire nxt_clk_en = ~trip_ff & (~modulating | on_phase);
	wire hyst_done = (hyst_ff == 16'(HYST_CYC - 1));

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			TTC_IDLE: if (hot_any) nxt_state = TTC_AUTO; // [R1]
			TTC_AUTO: if (!hot_any) nxt_state = TTC_HYST;
			TTC_HYST: begin
				if (hot_any) nxt_state = TTC_AUTO;
				else if (hyst_done) nxt_state = TTC_IDLE; // [R6]
			end
			default: nxt_state = TTC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= TTC_IDLE;
			hyst_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			hyst_ff <= (state_ff == TTC_HYST && !hyst_done) ?
				hyst_ff + 16'h0001 : 16'h0000;
		end
	end

	// One period spans eight eighths, so off time never passes the limit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sub_ff <= 16'h0000;
			step_ff <= 4'h0;
		end else if (!modulating) begin
			sub_ff <= 16'h0000;
			step_ff <= 4'h0;
		end else begin
			sub_ff <= step_end ? 16'h0000 : sub_ff + 16'h0001; // [R5]
			if (period_end) step_ff <= 4'h0;
			else if (step_end) step_ff <= step_ff + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clk_en_ff <= 1'b1;
			cmc_ff <= CMC_RESET;
		end else begin
			clk_en_ff <= nxt_clk_en;
			if (cmc_wr) cmc_ff <= cmc_wdata; // [R8]
		end
	end

	// Trip latches until reset; the supply is expected to go away
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) trip_ff <= 1'b0;
		else if (sens_trip_temp) trip_ff <= 1'b1; // [R15] [R16]
	end

	// Interrupt held while clocks are off, released when they return
	wire irq_take = clk_en_ff & (irq_pend_ff | irq_req);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) irq_pend_ff <= 1'b0;
		else irq_pend_ff <= (irq_pend_ff | irq_req) & ~clk_en_ff; // [R3]
	end

	// Edge events on the combined hot level; one-cycle pulses
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hot_prev_ff <= 1'b0;
			irq_hot_ff <= 1'b0;
			irq_cool_ff <= 1'b0;
		end else begin
			hot_prev_ff <= hot_any;
			irq_hot_ff <= cfg.hot_irq_en & hot_any & ~hot_prev_ff; // [R13]
			irq_cool_ff <= cfg.cool_irq_en & ~hot_any & hot_prev_ff; // [R13]
		end
	end

	assign cmc_rdata = cmc_ff;
	assign snoop_ack = snoop_req & ~trip_ff; // [R3]
	assign irq_service = irq_take; // [R3]
	assign hot_indicator_n_out = 1'b0; // [R19]
	assign hot_indicator_n_oe = own_hot; // [R11] [R19]
	assign overheat_trip_n = ~trip_ff; // [R15]
	assign core_shutdown = trip_ff;
	assign stat.throttle_active = auto_on | sw_on;
	assign stat.core_clk_en = clk_en_ff;
	assign stat.irq_hot = irq_hot_ff;
	assign stat.irq_cool = irq_cool_ff;

	a_trip_sticky: assert property ( // [R15]
		@(posedge clk) disable iff (!resetn)
		!overheat_trip_n |=> !overheat_trip_n)
		else $error("trip output released");
	// Clock gate is registered, so it drops one cycle after the trip output
	a_trip_follows: assert property ( // [R15]
		@(posedge clk) disable iff (!resetn)
		sens_trip_temp |=> !overheat_trip_n ##1 !stat.core_clk_en)
		else $error("trip not taken");
	a_trip_gate: assert property ( // [R15]
		@(posedge clk) disable iff (!resetn)
		trip_ff |=> !stat.core_clk_en)
		else $error("core clock runs after trip");
	a_hot_drive: assert property ( // [R11]
		@(posedge clk) disable iff (!resetn)
		sens_max_temp |-> hot_indicator_n_oe && !hot_indicator_n_out)
		else $error("hot pin not driven low");
	a_auto_start: assert property ( // [R1]
		@(posedge clk) disable iff (!resetn)
		(sens_max_temp && cfg.tm_enable && !trip_ff) |=> auto_on)
		else $error("auto throttle not engaged");
	a_ext_force: assert property ( // [R14]
		@(posedge clk) disable iff (!resetn)
		(!ext_level && cfg.tm_enable) |=> auto_on)
		else $error("external hot ignored");
	a_hyst_hold: assert property ( // [R6]
		@(posedge clk) disable iff (!resetn)
		($fell(hot_any) && state_ff == TTC_AUTO) |=> state_ff != TTC_IDLE)
		else $error("throttle ended without hysteresis");
	a_hyst_full: assert property ( // [R6]
		@(posedge clk) disable iff (!resetn)
		(state_ff == TTC_HYST && !hyst_done) |=> state_ff != TTC_IDLE)
		else $error("hysteresis cut short");
	a_sw_start: assert property ( // [R8]
		@(posedge clk) disable iff (!resetn)
		(cmc_wr && cmc_wdata[CMC_EN_BIT]) |=> sw_on)
		else $error("software modulation not started");
	a_irq_held: assert property ( // [R3]
		@(posedge clk) disable iff (!resetn)
		(irq_req && !clk_en_ff) |-> !irq_service ##1 irq_pend_ff)
		else $error("interrupt lost while clocks off");
	a_snoop_pass: assert property ( // [R3]
		@(posedge clk) disable iff (!resetn)
		(snoop_req && !trip_ff) |-> snoop_ack)
		else $error("snoop blocked while running");
	// A trip may freeze the gate low for good, so it ends the check
	a_off_bound: assert property ( // [R5]
		@(posedge clk) disable iff (!resetn || trip_ff)
		(modulating && $fell(clk_en_ff)) |-> ##[1:60] clk_en_ff)
		else $error("clock off too long");
	a_auto_duty: assert property ( // [R10]
		@(posedge clk) disable iff (!resetn)
		(auto_on && !trip_ff) |=> stat.core_clk_en ==
			($past(step_ff) < {1'b0, FACTORY_ON_EIGHTHS}))
		else $error("auto duty overridden");
	a_sw_duty: assert property ( // [R9]
		@(posedge clk) disable iff (!resetn)
		(sw_on && !auto_on && !trip_ff) |=> stat.core_clk_en ==
			($past(step_ff) < {1'b0, $past(sw_eighths)}))
		else $error("software duty not applied");
endmodule

/* bench/ttc_platform.sv */
// Platform thermal monitor model: regulator hot request, supply removal.
// Assumes the bench resolves the hot wire with a pull-up.
`timescale 1ns/1ns
module ttc_platform (
	input wire logic clk,
	input wire logic vr_hot,
	input wire logic overheat_trip_n,
	output logic pull_oe,
	output logic vcore_on
);
	// Regulator pulls the shared hot wire low while it runs hot;
	// supply never returns once a trip has been seen
	initial begin
		pull_oe = 1'b0;
		vcore_on = 1'b1;
		forever begin
			@(posedge clk);
			pull_oe <= vr_hot;
			if (!overheat_trip_n) vcore_on <= 1'b0;
		end
	end
endmodule

/* bench/ttc_top_tb.sv */
// Self-checking bench for the thermal clock throttle block.
// Assumes the package constants; hot wire has a pull-up.
`timescale 1ns/1ns
module ttc_top_tb;
	import ttc_pkg::*;
	logic clk, resetn, sens_max_temp, sens_trip_temp, cmc_wr, irq_req;
	logic snoop_req, snoop_ack, irq_service, vr_hot, hot_wire;
	logic dut_out, dut_oe, pull_oe, vcore_on, overheat_trip_n, core_shutdown;
	logic [4:0] cmc_wdata, cmc_rdata, v;
	ttc_cfg_s cfg;
	ttc_stat_s stat;
	int seed, errors, n_checks, on, run, n_hot, n_cool, n_svc;
	assign hot_wire = !(dut_oe || pull_oe);
	ttc_top uut (.clk(clk), .resetn(resetn), .sens_max_temp(sens_max_temp),
		.sens_trip_temp(sens_trip_temp), .cfg(cfg), .cmc_wr(cmc_wr),
		.cmc_wdata(cmc_wdata), .cmc_rdata(cmc_rdata), .irq_req(irq_req),
		.snoop_req(snoop_req), .snoop_ack(snoop_ack),
		.irq_service(irq_service), .hot_indicator_n_in(hot_wire),
		.hot_indicator_n_out(dut_out), .hot_indicator_n_oe(dut_oe),
		.overheat_trip_n(overheat_trip_n), .core_shutdown(core_shutdown),
		.stat(stat));
	ttc_platform plat (.clk(clk), .vr_hot(vr_hot),
		.overheat_trip_n(overheat_trip_n), .pull_oe(pull_oe),
		.vcore_on(vcore_on));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (stat.irq_hot === 1'b1) n_hot++;
		if (stat.irq_cool === 1'b1) n_cool++;
		if (irq_service === 1'b1) n_svc++;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [4:0] d);
		@(negedge clk);
		cmc_wr = 1'h1;
		cmc_wdata = d;
		@(negedge clk);
		cmc_wr = 1'h0;
	endtask
	// Clock-on count and longest off run; snoops must pass throughout
	task automatic measure(input int n);
		int r;
		on = 0;
		run = 0;
		r = 0;
		repeat (n) begin
			@(negedge clk);
			snoop_req = 1'($random(seed));
			#1 check(snoop_ack, snoop_req);
			if (stat.core_clk_en === 1'b1) on++;
			if (stat.core_clk_en !== 1'b1) r++;
			else r = 0;
			if (r > run) run = r;
		end
	endtask
	// Tolerance of half an eighth absorbs partial periods in the window
	function automatic logic near(input int eighths);
		return (on >= eighths * 60 - 30) && (on <= eighths * 60 + 30);
	endfunction
	initial begin
		#(50 * 20000);
		errors++;
		results;
	end
	initial begin
		seed = 67423;
		{sens_max_temp, sens_trip_temp, cmc_wr, irq_req, snoop_req} = '0;
		vr_hot = 1'h0;
		cmc_wdata = 5'h00;
		cfg = '{tm_enable: 1'h1, hot_irq_en: 1'h1, cool_irq_en: 1'h1};
		resetn = 1'h0;
		repeat (5) @(negedge clk);
		resetn = 1'h1;
		check(cmc_rdata, CMC_RESET);
		check(overheat_trip_n, 1'h1);
		check(stat.core_clk_en, 1'h1);
		repeat (20) begin
			v = 5'($random(seed));
			wr(v);
			check(cmc_rdata, v);
		end
		for (int d = 0; d < 8; d++) begin
			wr({1'h1, d[2:0], 1'h0});
			measure(480);
			check(near(d == 0 ? 1 : d), 1'h1);
		end
		// Event counters are never cleared; expected totals accumulate
		check(16'(n_hot), 16'h0);
		sens_max_temp = 1'h1;
		repeat (3) @(negedge clk);
		check(dut_oe, 1'h1);
		check(dut_out, 1'h0);
		check(stat.throttle_active, 1'h1);
		measure(480);
		check(near(FACTORY_ON_EIGHTHS), 1'h1);
		check(run <= OFF_MAX_CYC, 1'h1);
		check(16'(n_hot), 16'h1);
		// Raise the request in an off stretch so it has to be held
		while (stat.core_clk_en !== 1'b0) @(negedge clk);
		irq_req = 1'h1;
		#1 check(irq_service, 1'h0);
		@(negedge clk);
		irq_req = 1'h0;
		repeat (70) @(negedge clk);
		check(16'(n_svc), 16'h1);
		wr(5'h00);
		sens_max_temp = 1'h0;
		repeat (HYST_CYC - 50) @(negedge clk);
		check(stat.throttle_active, 1'h1);
		// A one-cycle reheat inside the hold restarts the timer
		sens_max_temp = 1'h1;
		@(negedge clk);
		sens_max_temp = 1'h0;
		repeat (HYST_CYC - 50) @(negedge clk);
		check(stat.throttle_active, 1'h1);
		repeat (100) @(negedge clk);
		check(stat.throttle_active, 1'h0);
		check(stat.core_clk_en, 1'h1);
		check(16'(n_hot), 16'h2);
		check(16'(n_cool), 16'h2);
		vr_hot = 1'h1;
		@(negedge clk);
		check(stat.throttle_active, 1'h0);
		repeat (8) @(negedge clk);
		check(stat.throttle_active, 1'h1);
		check(dut_oe, 1'h0);
		check(16'(n_hot), 16'h3);
		vr_hot = 1'h0;
		repeat (8) @(negedge clk);
		check(16'(n_cool), 16'h3);
		cfg.tm_enable = 1'h0;
		sens_trip_temp = 1'h1;
		@(negedge clk);
		sens_trip_temp = 1'h0;
		repeat (3) @(negedge clk);
		check(overheat_trip_n, 1'h0);
		check(core_shutdown, 1'h1);
		check(stat.core_clk_en, 1'h0);
		check(vcore_on, 1'h0);
		snoop_req = 1'h1;
		#1 check(snoop_ack, 1'h0);
		// Only a reset clears the trip
		@(negedge clk);
		resetn = 1'h0;
		@(negedge clk);
		check(overheat_trip_n, 1'h1);
		resetn = 1'h1;
		check(cmc_rdata, CMC_RESET);
		check(stat.throttle_active, 1'h0);
		@(negedge clk);
		check(stat.core_clk_en, 1'h1);
		check(snoop_ack, 1'h1);
		results;
	end
endmodule
